// File: rtl/dma_channel_stop_terminate.sv
/*
 * one dma channel: apb registers, request-pending flag, enable stop and resume,
 * forced termination via the initialise bit, alignment of 16-bit transfers.
 * assumes: single clock clk_sys, apb master on the same clock, target answers
 * each transfer with xfer_ready while xfer_valid is high.
 */
// The APB slave port and the register addresses were decided locally.
// What this block does and what software must do
// [R1] clearing enable halts further transfers
// [R2] setting enable resumes where it stopped
// [R3] pending flag shows a held request
// [R4] initialise bit forces channel termination
// [R5] count reloads only when termination completes
// [R6] odd address lsb treated as zero on 16-bit transfers
// [R7] software avoids misaligned 16-bit transfers
// [R8] software keeps addresses inside target area
// [R9] stop source, wait pending clear first
// [R10] clear enable twice, thrice for ram
// [R11] set init until count equals saved
// [R12] restart request source after resuming
// [R13] count holds remaining, decrements per transfer
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_defs.svh"

module dma_channel_stop_terminate #(
    parameter int CW = 16                        // transfer count width
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 dma_req,
    output logic                      xfer_valid,
    output dma_chan_pkg::xfer_s       xfer,
    input  wire logic                 xfer_ready
);

    dma_chan_pkg::chan_state_e state;            // sequencer state
    logic            ctrl_en;                    // channel enable
    logic            size16;                     // 16-bit transfer width
    logic [CW-1:0]   init_cnt;                   // initial transfer count
    logic [CW-1:0]   count;                      // transfers remaining
    logic [31:0]     src_base;                   // programmed source
    logic [31:0]     dst_base;                   // programmed destination
    logic [31:0]     src_cur;                    // running source
    logic [31:0]     dst_cur;                    // running destination
    logic            pend;                       // request held pending
    logic            tc;                         // terminal count reached
    logic            wr;                         // apb write strobe
    logic            wr_ctrl;                    // control write
    logic            init_req;                   // initialise bit written
    logic            init_ok;                    // termination completes
    logic            start_go;                   // launch one transfer
    logic            done;                       // transfer accepted by target
    logic            last;                       // final transfer done
    logic            mapped;                     // address decodes
    logic [31:0]     step;                       // address increment

    // drop the lsb on 16-bit transfers
    function automatic logic [31:0] align(input logic [31:0] a, input logic s16);
        align = s16 ? {a[31:1], 1'b0} : a;
    endfunction

    // decode of a register offset, used for reads, writes and errors
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // apb strobes; no wait states
    assign wr       = psel && penable && pwrite;
    assign wr_ctrl  = wr && hit(paddr, `OFF_CTRL);
    assign init_req = wr_ctrl && pwdata[`CTRL_INIT];
    assign pready   = psel && penable;
    assign mapped   = hit(paddr, `OFF_CTRL) || hit(paddr, `OFF_SRC) ||
                      hit(paddr, `OFF_DST) || hit(paddr, `OFF_COUNT) ||
                      hit(paddr, `OFF_STATUS);
    assign pslverr  = psel && penable && !mapped;

    // [R4] forced termination: only completes with no transfer in flight
    assign init_ok  = init_req && (state == dma_chan_pkg::st_idle);
    // [R1] launch only while enabled; an init write in the same cycle also blocks it
    assign start_go = (state == dma_chan_pkg::st_idle) && ctrl_en && pend &&
                      (count != '0) && !init_req;
    assign done     = (state == dma_chan_pkg::st_move) && xfer_ready;
    assign last     = done && (count == CW'(1));
    assign step     = size16 ? 32'h0000_0002 : 32'h0000_0001;
    assign xfer_valid = (state == dma_chan_pkg::st_move);

    // sequencer: one transfer per serviced request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= dma_chan_pkg::st_idle;
        end else begin
            case (state)
                dma_chan_pkg::st_idle: begin
                    if (start_go) begin
                        state <= dma_chan_pkg::st_move;
                    end
                end
                dma_chan_pkg::st_move: begin
                    // an in-flight transfer always finishes, even if disabled
                    if (done) begin
                        state <= dma_chan_pkg::st_idle;
                    end
                end
                default: state <= dma_chan_pkg::st_idle;
            endcase
        end
    end

    // transfer descriptor, captured at launch
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xfer <= '0;
        end else if (start_go) begin
            // [R6] lsb forced low on 16-bit transfers
            xfer.src    <= align(src_cur, size16);
            xfer.dst    <= align(dst_cur, size16);
            xfer.size16 <= size16;
        end
    end

    // control bits
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_en <= 1'b0;
            size16  <= 1'b0;
        end else if (wr_ctrl) begin
            // [R1] [R2] enable written directly; resume keeps position
            ctrl_en <= pwdata[`CTRL_EN];
            size16  <= pwdata[`CTRL_SIZE16];
        end else if (last) begin
            // channel drops itself at terminal count
            ctrl_en <= 1'b0;
        end
    end

    // addresses: base written by software, running copy advances
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            src_base <= `RST_ADDR;
            dst_base <= `RST_ADDR;
            src_cur  <= `RST_ADDR;
            dst_cur  <= `RST_ADDR;
        end else begin
            if (wr && hit(paddr, `OFF_SRC)) begin
                src_base <= pwdata;
                src_cur  <= pwdata;
            end else if (init_ok) begin
                src_cur <= src_base;
            end else if (done) begin
                src_cur <= src_cur + step;
            end
            if (wr && hit(paddr, `OFF_DST)) begin
                dst_base <= pwdata;
                dst_cur  <= pwdata;
            end else if (init_ok) begin
                dst_cur <= dst_base;
            end else if (done) begin
                dst_cur <= dst_cur + step;
            end
        end
    end

    // transfer count
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt <= CW'(`RST_COUNT);
            count    <= CW'(`RST_COUNT);
        end else if (wr && hit(paddr, `OFF_COUNT)) begin
            init_cnt <= pwdata[CW-1:0];
            count    <= pwdata[CW-1:0];
        end else if (init_ok) begin
            // [R5] reload only on a completed termination
            count <= init_cnt;
        end else if (done) begin
            // [R13] one fewer remaining
            count <= count - CW'(1);
        end
    end

    // pending flag: a new request wins over its own clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 1'b0;
        // [R3] held until serviced or terminated
        end else if (dma_req) begin
            pend <= 1'b1;
        end else if (start_go || init_ok) begin
            pend <= 1'b0;
        end
    end

    // terminal count flag, write one to clear, set wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tc <= 1'b0;
        end else if (last) begin
            tc <= 1'b1;
        end else if (wr && hit(paddr, `OFF_STATUS) && pwdata[`STAT_TC]) begin
            tc <= 1'b0;
        end
    end

    // read data captured in the setup phase, valid through access
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (hit(paddr, `OFF_CTRL)) begin
                prdata <= {29'h0, size16, 1'b0, ctrl_en};
            end else if (hit(paddr, `OFF_SRC)) begin
                prdata <= src_cur;
            end else if (hit(paddr, `OFF_DST)) begin
                prdata <= dst_cur;
            end else if (hit(paddr, `OFF_COUNT)) begin
                prdata <= 32'(count);
            end else if (hit(paddr, `OFF_STATUS)) begin
                // [R3] pending flag visible to software
                prdata <= {29'h0, xfer_valid, tc, pend};
            end else begin
                prdata <= '0;
            end
        end
    end

    // checks

    sequence launch_s;
        start_go;
    endsequence

    sequence moving_s;
        xfer_valid && !done;
    endsequence

    // [R1] halt holds while disabled
    stop_halts_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R1]
        (state == dma_chan_pkg::st_idle && !ctrl_en) |=> state == dma_chan_pkg::st_idle)
        else $error("transfer started while disabled");

    // [R2] re-enable keeps position, then can launch
    resume_pos_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
        $rose(ctrl_en) |-> (count == $past(count) || $past(init_ok) || $past(done)))
        else $error("resume lost channel position");

    // [R2] launch leads to an issued transfer
    launch_issue_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
        launch_s |=> moving_s or (xfer_valid && done))
        else $error("launch without transfer");

    // [R3] request sets the flag next cycle
    pend_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
        dma_req |=> pend)
        else $error("request not held pending");

    // [R4] completed termination reloads count and idles
    init_term_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
        init_ok |=> (count == $past(init_cnt) && state == dma_chan_pkg::st_idle))
        else $error("termination did not reload");

    // [R5] blocked termination leaves remaining count
    init_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
        (init_req && xfer_valid && !done) |=> count == $past(count))
        else $error("count changed on blocked termination");

    // [R6] 16-bit transfers issue even addresses
    align_16_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R6]
        (xfer_valid && xfer.size16) |-> (!xfer.src[0] && !xfer.dst[0]))
        else $error("odd address on 16-bit transfer");

    // [R13] each completed transfer takes one off
    count_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R13]
        (done && !wr) |=> count == CW'($past(count) - CW'(1)))
        else $error("count not decremented");

    // named step of a completed termination
    sequence term_s;
        init_ok;
    endsequence

    // [R4] completed termination rewinds both addresses
    init_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
        term_s |=> (src_cur == $past(src_base) && dst_cur == $past(dst_base)))
        else $error("termination did not rewind addresses");

    // [R3] launch without a fresh request clears the flag
    pend_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
        (start_go && !dma_req) |=> !pend)
        else $error("pending flag kept after launch");

    // [R1] a stopped idle channel keeps its count
    stop_count_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R1]
        (state == dma_chan_pkg::st_idle && !ctrl_en && !wr) |=> count == $past(count))
        else $error("count moved while stopped");

    // [R13] final transfer flags terminal count and drops enable
    last_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R13]
        (last && !wr_ctrl) |=> (tc && !ctrl_en))
        else $error("terminal count not flagged");

endmodule // dma_channel_stop_terminate
`default_nettype wire

// File: rtl/dma_chan_defs.svh
/*
 * register offsets, field positions and reset values of the dma channel control block.
 * assumes: included by bare name from design and bench files.
 */
`ifndef DMA_CHAN_DEFS_SVH
`define DMA_CHAN_DEFS_SVH

// byte offsets on the apb bus
`define OFF_CTRL    12'h000
`define OFF_SRC     12'h004
`define OFF_DST     12'h008
`define OFF_COUNT   12'h00c
`define OFF_STATUS  12'h010

// control register fields
`define CTRL_EN     0
`define CTRL_INIT   1
`define CTRL_SIZE16 2

// status register fields
`define STAT_PEND   0
`define STAT_TC     1
`define STAT_BUSY   2

// reset values
`define RST_ADDR    32'h0000_0000
`define RST_COUNT   16'h0000

`endif

// File: rtl/dma_chan_pkg.sv
/*
 * types shared by the dma channel control block.
 * assumes: nothing beyond a systemverilog compiler.
 */
package dma_chan_pkg;

    // channel sequencer states, one-hot
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_move = 2'b10
    } chan_state_e;

    // one transfer handed to the target side
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic        size16;
    } xfer_s;

endpackage

// File: dv/dma_target_model.sv
/*
 * behavioural memory/peripheral target that accepts channel transfers.
 * assumes: shares clk_sys and rst_b with the channel; stall set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module dma_target_model (
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                xfer_valid,
    input  wire dma_chan_pkg::xfer_s xfer,
    input  wire logic [7:0]          stall,
    output logic                     xfer_ready,
    output dma_chan_pkg::xfer_s      last,
    output logic [7:0]               seen
);
    logic [7:0] wait_cnt;  // cycles the offer has stood

    // ready after stall+1 cycles, accept one cycle later; ready never shown without an offer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xfer_ready <= 1'b0;
            wait_cnt   <= 8'h00;
            seen       <= 8'h00;
            last       <= '0;
        end else if (xfer_valid && xfer_ready) begin
            xfer_ready <= 1'b0;
            wait_cnt   <= 8'h00;
            seen       <= seen + 8'h01;
            last       <= xfer;
        end else if (xfer_valid) begin
            xfer_ready <= (wait_cnt >= stall);
            wait_cnt   <= wait_cnt + 8'h01;
        end
    end
endmodule // dma_target_model

`default_nettype wire

// File: dv/tb_dma_channel_stop_terminate.sv
/*
 * self-checking bench: apb register tasks, request pulses, target model.
 * assumes: zero-wait apb slave, register map of dma_chan_defs.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_defs.svh"

module tb_dma_channel_stop_terminate;
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, dma_req = 1'b0, xfer_valid, xfer_ready;
    logic [7:0] stall = 8'h00, seen;
    dma_chan_pkg::xfer_s xfer, last;
    int mismatches = 0, num_checks = 0, cycles = 0, n;

    always #5 clk_sys = ~clk_sys;

    dma_channel_stop_terminate #(.CW(16)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req),
        .xfer_valid(xfer_valid), .xfer(xfer), .xfer_ready(xfer_ready));
    dma_target_model tgt (.clk_sys(clk_sys), .rst_b(rst_b), .xfer_valid(xfer_valid),
        .xfer(xfer), .stall(stall), .xfer_ready(xfer_ready), .last(last), .seen(seen));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard, far above the roughly 150 cycles used
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // setup then access held until pready sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && cycles < 20000);
        q = prdata;
        chk({31'h0, pslverr}, {31'h0, a > `OFF_STATUS});
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge, so a following setup never reassigns psel in this step
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic req;  // one-cycle request pulse
        dma_req <= 1'b1;
        @(posedge clk_sys);
        dma_req <= 1'b0;
    endtask

    task automatic wait_seen(input logic [7:0] cnt);
        n = 0;
        while (seen !== cnt && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(`OFF_COUNT, 32'h0);
        rd(`OFF_STATUS, 32'h0);
        rd(12'h020, 32'h0);
        $display("test reset_map done");
        // odd addresses inside one area, 16-bit size
        apb(1'b1, `OFF_SRC, 32'h101);
        apb(1'b1, `OFF_DST, 32'h203);
        apb(1'b1, `OFF_COUNT, 32'h3);
        apb(1'b1, `OFF_CTRL, 32'h5);
        req();
        wait_seen(8'h01);
        chk(last.src, 32'h100);
        chk(last.dst, 32'h202);
        chk({31'h0, last.size16}, 32'h1);
        rd(`OFF_COUNT, 32'h2);
        $display("test align_count done");
        // stop with source quiet and nothing pending, then request while stopped
        rd(`OFF_STATUS, 32'h0);
        apb(1'b1, `OFF_CTRL, 32'h4);
        req();
        repeat (10) @(posedge clk_sys);
        chk({24'h0, seen}, 32'h1);
        rd(`OFF_STATUS, 32'h1);
        stall <= 8'h08;
        apb(1'b1, `OFF_CTRL, 32'h5);
        n = 0;
        while (xfer_valid !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        apb(1'b1, `OFF_CTRL, 32'h6); // init with transfer in flight
        wait_seen(8'h02);
        chk(last.src, 32'h102);
        rd(`OFF_COUNT, 32'h1);
        rd(`OFF_STATUS, 32'h0);
        $display("test stop_resume done");
        // forced termination: clear enable thrice, retry init
        stall <= 8'h00;
        repeat (3) apb(1'b1, `OFF_CTRL, 32'h4);
        n = 0;
        do begin
            apb(1'b1, `OFF_CTRL, 32'h6);
            apb(1'b0, `OFF_COUNT, 32'h0);
            n++;
        end while (q !== 32'h3 && n < 4);
        chk(q, 32'h3);
        apb(1'b1, `OFF_CTRL, 32'h5);
        req();
        wait_seen(8'h03);
        chk(last.src, 32'h100);
        rd(`OFF_COUNT, 32'h2);
        $display("test terminate done");
        // run the count out: terminal count set, enable dropped
        req();
        wait_seen(8'h04);
        req();
        wait_seen(8'h05);
        chk(last.src, 32'h104);
        rd(`OFF_COUNT, 32'h0);
        rd(`OFF_STATUS, 32'h2);
        rd(`OFF_CTRL, 32'h4);
        rd(`OFF_SRC, 32'h107);
        rd(`OFF_DST, 32'h209);
        apb(1'b1, `OFF_STATUS, 32'h2);
        rd(`OFF_STATUS, 32'h0);
        $display("test terminal_count done");
        // reset after the run returns control, source and count to zero
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(`OFF_CTRL, 32'h0);
        rd(`OFF_SRC, 32'h0);
        rd(`OFF_COUNT, 32'h0);
        $display("test reset_again done");
        stop_test();
    end
endmodule // tb_dma_channel_stop_terminate

`default_nettype wire
